// ==== verilog/ubg_pkg.sv ====
// constants for the serial port 0 baud generator and LIN extension
package ubg_pkg;
    // register addresses
    localparam logic [7:0] ADDR_RELOAD  = 8'h9a;
    localparam logic [7:0] ADDR_LINCFG  = 8'h9d;
    localparam logic [7:0] ADDR_COUNTER = 8'h9e;
    localparam logic [7:0] ADDR_AUX     = 8'ha4;
    localparam logic [7:0] ADDR_ENH     = 8'hb9;
    localparam logic [3:0] PAGE_0       = 4'h0;
    localparam logic [3:0] PAGE_3       = 4'h3;
    // enhanced control fields
    localparam int ENH_RUN   = 7;
    localparam int ENH_PRESC = 6;
    localparam int ENH_TXSEL = 5;
    localparam int ENH_RXSEL = 4;
    localparam int ENH_CKOE  = 3;
    localparam int ENH_ART   = 2;
    // LIN configuration fields
    localparam int LIN_SBF   = 7;
    localparam int LIN_TXER  = 6;
    localparam int LIN_B16   = 5;
    localparam int LIN_ABR   = 4;
    localparam int LIN_DIR   = 3;
    localparam int LIN_BRK   = 2;
    // writable bits, low two read as zero
    localparam logic [7:0] CFG_MASK = 8'hfc;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // timing counts
    localparam logic [3:0] PRESC_LAST = 4'hb;
    localparam logic [3:0] OVS_LAST   = 4'hf;
    localparam logic [4:0] BRK_SHORT  = 5'h0d;
    localparam logic [4:0] BRK_LONG   = 5'h10;
    localparam logic [4:0] BRK_DETECT = 5'h0b;
    localparam logic [2:0] SYNC_EDGES = 3'h4;
    localparam int         MEAS_SHIFT = 7;
    localparam int         MEAS_W     = 16;
    typedef enum logic [2:0] {
        LIN_IDLE  = 3'b000,
        LIN_TXBRK = 3'b001,
        LIN_RXBRK = 3'b010,
        LIN_SWAIT = 3'b011,
        LIN_SMEAS = 3'b100
    } ubg_lin_state_type;
endpackage : ubg_pkg

// ==== verilog/ubg_buf_if.sv ====
// handshake carrier between the extension and its word buffer
`timescale 1ns/1ps
interface ubg_buf_if #(parameter int W = 8);
    logic [W-1:0] in_data;
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] out_data;
    logic         out_valid;
    logic         out_ready;
    modport buf_side (input in_data, input in_valid, input out_ready,
                      output in_ready, output out_data, output out_valid);
    modport user_side (output in_data, output in_valid, output out_ready,
                       input in_ready, input out_data, input out_valid);
endinterface : ubg_buf_if

// ==== verilog/ubg_buf2.sv ====
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module ubg_buf2 #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // handshake sides
    ubg_buf_if.buf_side bif
);
    logic [W-1:0] mem_ff [2];
    logic         wp_ff;
    logic         rp_ff;
    logic [1:0]   cnt_ff;
    logic         push;
    logic         pop;

    assign bif.in_ready  = (cnt_ff != 2'd2);
    assign bif.out_valid = (cnt_ff != 2'd0);
    assign bif.out_data  = mem_ff[rp_ff];
    assign push = bif.in_valid & bif.in_ready;
    assign pop  = bif.out_valid & bif.out_ready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else if (push) begin
            mem_ff[wp_ff] <= bif.in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'd0;
        end else begin
            if (push) wp_ff <= ~wp_ff;
            if (pop) rp_ff <= ~rp_ff;
            if (push && !pop) cnt_ff <= cnt_ff + 2'd1;
            else if (pop && !push) cnt_ff <= cnt_ff - 2'd1;
        end
    end
endmodule : ubg_buf2

// ==== verilog/ubg_top.sv ====
// serial port 0 baud generator, clock output and LIN extension
`timescale 1ns/1ps
// Notes on behaviour
// - counter advances only while the run bit is set
// - prescale bit 0 counts system clock over 12, 1 counts every clock
// - transmit time base is counter overflow when selected, else timer overflow
// - receive time base is counter overflow when selected, else timer overflow
// - clock output pin is driven only while its enable bit is set
// - clock output toggles on each overflow, half the overflow rate
// - auto repeat transmit bit turns repeated sending on or off
// - eight bit up counter reloads from reload register on overflow outside sixteen bit mode
// - reload write also loads counter while stopped, not while running
// - counter always readable, writable only in page 0, never touches reload value outside sixteen bit mode
// - overflow pulse keeps feeding other peripherals regardless of engine state
// - access select high maps shared address to enhanced control
// - break detection sets sync break flag with tx or rx done; software clears
// - transmit mode mismatch on bus sets transmit error flag; software clears
// - master break lasts 13 bits, or 16 bits with length bit set
// - auto baud measures sync field, sets reload, clears its own request bit
// - direction bit 0 makes LIN engine receive, 1 transmit
// - break bit: master breaks on next buffer write, slave awaits break; self-clears
// - access select low maps shared address to the address mask register
// - timer mode with data order bit set chains counter into sixteen bits
module ubg_top
    import ubg_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // special function register bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic [3:0] sfr_page,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_hit,
    // controls held by the port core
    input  wire logic       ctrl_access_sel,
    input  wire logic       data_order_bit,
    input  wire logic       timer_mode,
    input  wire logic       timer_ovf,
    // serial buffer writes towards the frame engine
    input  wire logic       sbuf_wr,
    input  wire logic [7:0] sbuf_wdata,
    output logic            sbuf_ready,
    output logic      [7:0] tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    input  wire logic       core_txd,
    // time bases and flags to the frame engine
    output logic            baud_overflow,
    output logic            tx_time_base,
    output logic            rx_time_base,
    output logic            tx_done_set,
    output logic            rx_done_set,
    output logic            auto_repeat_tx,
    output logic      [7:0] addr_mask,
    output logic      [7:0] aux_sel_page0,
    output logic      [7:0] aux_sel_page3,
    // pins
    input  wire logic       lin_rxd,
    output logic            lin_txd,
    output logic            clock_out_pin,
    output logic            clock_out_oe
);
    logic [7:0]        enh_ff;
    logic [7:0]        lcfg_ff;
    logic [7:0]        mask_ff;
    logic [7:0]        aux0_ff;
    logic [7:0]        aux3_ff;
    logic [7:0]        reload_ff;
    logic [7:0]        cnt_ff;
    logic [3:0]        presc_ff;
    logic              ovf_ff;
    logic              ck_ff;
    logic [7:0]        rdata_ff;
    logic              hit_ff;
    logic              rx_s1_ff;
    logic              rx_s2_ff;
    logic              rx_s3_ff;
    logic              txd_ff;
    logic [1:0]        txd_dly_ff;
    logic [3:0]        sub_ff;
    logic [4:0]        bit_ff;
    logic [2:0]        edge_ff;
    logic [MEAS_W-1:0] meas_ff;
    logic              txdone_ff;
    logic              rxdone_ff;
    ubg_lin_state_type st_ff;
    ubg_lin_state_type nxt_st;

    logic       wr_reload;
    logic       wr_cnt;
    logic       wr_lcfg;
    logic       wr_enh;
    logic       wr_mask;
    logic       wr_aux0;
    logic       wr_aux3;
    logic       run;
    logic       presc_tick;
    logic       tick;
    logic       mode16;
    logic       ovf_now;
    logic       bit_tick;
    logic       rx_fall;
    logic       rx_rise;
    logic       brk_done_tx;
    logic       brk_done_rx;
    logic       abr_load;
    logic [7:0] abr_val;
    logic [MEAS_W-1:0] meas_rnd;
    logic       txer_set;
    logic       hold_tx;
    logic [4:0] brk_len;

    ubg_buf_if #(.W(8)) bif ();

    ubg_buf2 #(.W(8)) u_buf (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .bif      (bif)
    );

    // register decode
    assign wr_reload = sfr_wr && sfr_addr == ADDR_RELOAD && sfr_page == PAGE_0;
    assign wr_cnt    = sfr_wr && sfr_addr == ADDR_COUNTER && sfr_page == PAGE_0;
    assign wr_lcfg   = sfr_wr && sfr_addr == ADDR_LINCFG && sfr_page == PAGE_0;
    assign wr_enh    = sfr_wr && sfr_addr == ADDR_ENH && ctrl_access_sel;
    assign wr_mask   = sfr_wr && sfr_addr == ADDR_ENH && !ctrl_access_sel;
    assign wr_aux0   = sfr_wr && sfr_addr == ADDR_AUX && sfr_page == PAGE_0;
    assign wr_aux3   = sfr_wr && sfr_addr == ADDR_AUX && sfr_page == PAGE_3;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= RST_REG;
            hit_ff   <= 1'b0;
        end else if (sfr_rd) begin
            hit_ff <= 1'b1;
            case (sfr_addr)
                ADDR_RELOAD:  rdata_ff <= reload_ff;
                ADDR_COUNTER: rdata_ff <= cnt_ff;
                ADDR_LINCFG:  rdata_ff <= lcfg_ff & CFG_MASK;
                ADDR_ENH:     rdata_ff <= ctrl_access_sel ? (enh_ff & CFG_MASK) : mask_ff;
                ADDR_AUX:     rdata_ff <= (sfr_page == PAGE_3) ? aux3_ff : aux0_ff;
                default: begin
                    rdata_ff <= RST_REG;
                    hit_ff   <= 1'b0;
                end
            endcase
        end else begin
            hit_ff <= 1'b0;
        end
    end

    assign sfr_rdata = rdata_ff;
    assign sfr_hit   = hit_ff;

    // plain control registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enh_ff  <= RST_REG;
            mask_ff <= RST_REG;
            aux0_ff <= RST_REG;
            aux3_ff <= RST_REG;
        end else begin
            // low two bits dropped; software keeps them zero
            if (wr_enh) enh_ff <= sfr_wdata & CFG_MASK;
            if (wr_mask) mask_ff <= sfr_wdata;
            if (wr_aux0) aux0_ff <= sfr_wdata;
            if (wr_aux3) aux3_ff <= sfr_wdata;
        end
    end

    assign run            = enh_ff[ENH_RUN];
    assign auto_repeat_tx = enh_ff[ENH_ART];
    assign addr_mask      = mask_ff;
    assign aux_sel_page0  = aux0_ff;
    assign aux_sel_page3  = aux3_ff;

    // divide by 12 prescaler
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= 4'h0;
        end else if (presc_ff == PRESC_LAST) begin
            presc_ff <= 4'h0;
        end else begin
            presc_ff <= presc_ff + 4'h1;
        end
    end

    assign presc_tick = (presc_ff == PRESC_LAST);
    assign tick   = run && (enh_ff[ENH_PRESC] || presc_tick);
    assign mode16 = timer_mode && data_order_bit;
    assign ovf_now = tick && cnt_ff == 8'hff && (!mode16 || reload_ff == 8'hff);

    // counter and reload register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_ff <= RST_REG;
            cnt_ff    <= RST_REG;
        end else begin
            if (wr_reload) begin
                reload_ff <= sfr_wdata;
                if (!run) cnt_ff <= sfr_wdata;
            end else if (abr_load) begin
                reload_ff <= abr_val;
            end else if (tick && mode16 && cnt_ff == 8'hff) begin
                reload_ff <= reload_ff + 8'h01;
            end
            if (wr_cnt) begin
                cnt_ff <= sfr_wdata;
            end else if (tick) begin
                if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
                else if (mode16) cnt_ff <= 8'h00;
                else cnt_ff <= reload_ff;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) ovf_ff <= 1'b0;
        else ovf_ff <= ovf_now;
    end

    // overflow leaves regardless of engine state
    assign baud_overflow = ovf_ff;
    assign tx_time_base  = enh_ff[ENH_TXSEL] ? ovf_ff : timer_ovf;
    assign rx_time_base  = enh_ff[ENH_RXSEL] ? ovf_ff : timer_ovf;

    // clock output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) ck_ff <= 1'b0;
        else if (!enh_ff[ENH_CKOE]) ck_ff <= 1'b0;
        else if (ovf_ff) ck_ff <= ~ck_ff;
    end

    assign clock_out_pin = ck_ff;
    assign clock_out_oe  = enh_ff[ENH_CKOE];

    // bus input synchroniser and edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_s3_ff <= 1'b1;
        end else begin
            rx_s1_ff <= lin_rxd;
            rx_s2_ff <= rx_s1_ff;
            rx_s3_ff <= rx_s2_ff;
        end
    end

    assign rx_fall = rx_s3_ff && !rx_s2_ff;
    assign rx_rise = !rx_s3_ff && rx_s2_ff;

    // bit timing: sixteen overflows per bit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) sub_ff <= 4'h0;
        else if (st_ff == LIN_IDLE && rx_fall) sub_ff <= 4'h0;
        else if (ovf_ff) sub_ff <= sub_ff + 4'h1;
    end

    assign bit_tick = ovf_ff && sub_ff == OVS_LAST;
    assign brk_len  = lcfg_ff[LIN_B16] ? BRK_LONG : BRK_SHORT;

    // LIN engine
    always_comb begin
        nxt_st      = st_ff;
        brk_done_tx = 1'b0;
        brk_done_rx = 1'b0;
        abr_load    = 1'b0;
        case (st_ff)
            LIN_IDLE: begin
                if (lcfg_ff[LIN_BRK] && lcfg_ff[LIN_DIR] && bif.out_valid) nxt_st = LIN_TXBRK;
                else if (lcfg_ff[LIN_BRK] && !lcfg_ff[LIN_DIR] && rx_fall) nxt_st = LIN_RXBRK;
            end
            LIN_TXBRK: begin
                if (bit_tick && bit_ff == brk_len - 5'd1) begin
                    brk_done_tx = 1'b1;
                    nxt_st      = LIN_IDLE;
                end
            end
            LIN_RXBRK: begin
                if (rx_rise) begin
                    if (bit_ff >= BRK_DETECT) begin
                        brk_done_rx = 1'b1;
                        nxt_st = lcfg_ff[LIN_ABR] ? LIN_SWAIT : LIN_IDLE;
                    end else begin
                        nxt_st = LIN_IDLE;
                    end
                end
            end
            LIN_SWAIT: begin
                if (rx_fall) nxt_st = LIN_SMEAS;
            end
            LIN_SMEAS: begin
                if (rx_fall && edge_ff == SYNC_EDGES - 3'd1) begin
                    abr_load = 1'b1;
                    nxt_st   = LIN_IDLE;
                end
            end
            default: nxt_st = LIN_IDLE;
        endcase
    end

    // reload = 256 minus measured generator ticks over eight bits of sixteen ticks
    // rounded, the detecting cycle itself is not counted
    assign meas_rnd = meas_ff + 16'h0040;
    assign abr_val  = 8'h00 - meas_rnd[MEAS_SHIFT +: 8];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) st_ff <= LIN_IDLE;
        else st_ff <= nxt_st;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_ff  <= 5'h00;
            edge_ff <= 3'h0;
            meas_ff <= '0;
        end else begin
            if (st_ff != nxt_st) bit_ff <= 5'h00;
            else if (bit_tick && bit_ff != 5'h1f) bit_ff <= bit_ff + 5'h01;
            if (st_ff != LIN_SMEAS) begin
                edge_ff <= 3'h0;
                meas_ff <= '0;
            end else begin
                if (rx_fall) edge_ff <= edge_ff + 3'h1;
                // measured in prescaled generator ticks
                if (enh_ff[ENH_PRESC] || presc_tick) meas_ff <= meas_ff + 16'h0001;
            end
        end
    end

    // break drives the line low, otherwise the frame engine owns it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_ff     <= 1'b1;
            txd_dly_ff <= 2'b11;
        end else begin
            txd_ff     <= (nxt_st == LIN_TXBRK) ? 1'b0 : core_txd;
            txd_dly_ff <= {txd_dly_ff[0], txd_ff};
        end
    end

    assign lin_txd = txd_ff;
    // compare against what was driven two clocks back, matching the synchroniser
    assign txer_set = lcfg_ff[LIN_DIR] && bit_tick && (rx_s2_ff != txd_dly_ff[1]);

    // done pulses paired with the sync break flag
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txdone_ff <= 1'b0;
            rxdone_ff <= 1'b0;
        end else begin
            txdone_ff <= brk_done_tx;
            rxdone_ff <= brk_done_rx;
        end
    end

    assign tx_done_set = txdone_ff;
    assign rx_done_set = rxdone_ff;

    // LIN configuration: hardware set beats software clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lcfg_ff <= RST_REG;
        end else begin
            if (wr_lcfg) lcfg_ff <= sfr_wdata & CFG_MASK;
            if (brk_done_tx || brk_done_rx) lcfg_ff[LIN_SBF] <= 1'b1;
            if (txer_set) lcfg_ff[LIN_TXER] <= 1'b1;
            if (!wr_lcfg && (brk_done_tx || brk_done_rx)) lcfg_ff[LIN_BRK] <= 1'b0;
            if (!wr_lcfg && abr_load) lcfg_ff[LIN_ABR] <= 1'b0;
        end
    end

    // serial buffer path; data held back while a master break is pending or being sent
    assign hold_tx = lcfg_ff[LIN_BRK] && lcfg_ff[LIN_DIR] || st_ff == LIN_TXBRK;
    assign bif.in_data   = sbuf_wdata;
    assign bif.in_valid  = sbuf_wr;
    assign bif.out_ready = tx_ready && !hold_tx;
    assign sbuf_ready    = bif.in_ready;
    assign tx_data       = bif.out_data;
    assign tx_valid      = bif.out_valid && !hold_tx;
endmodule : ubg_top

// ==== test/ubg_top_props.sv ====
// assertions on the baud generator top ports
`timescale 1ns/1ps
module ubg_top_props
    import ubg_pkg::*;
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // register bus and levels
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       ctrl_access_sel,
    input wire logic       timer_ovf,
    // watched outputs
    input wire logic       baud_overflow,
    input wire logic       tx_time_base,
    input wire logic       rx_time_base,
    input wire logic       tx_done_set,
    input wire logic       rx_done_set,
    input wire logic       auto_repeat_tx,
    input wire logic [7:0] addr_mask,
    input wire logic       clock_out_pin,
    input wire logic       clock_out_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] enh_ff;
    logic       enh_wr;
    assign enh_wr = sfr_wr && sfr_addr == ADDR_ENH;
    // shadow of enhanced control
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) enh_ff <= RST_REG;
        else if (enh_wr && ctrl_access_sel) enh_ff <= sfr_wdata & CFG_MASK;
    end
    a_run_gate: assert property (!enh_ff[ENH_RUN] && !$past(enh_ff[ENH_RUN]) && !$past(enh_ff[ENH_RUN], 2) |-> !baud_overflow)
        else $error("overflow while stopped");
    a_presc_gap: assert property (baud_overflow && !enh_ff[ENH_PRESC] |=> !baud_overflow [*8])
        else $error("overflows too close with prescaler");
    a_tx_base_mux: assert property (tx_time_base == (enh_ff[ENH_TXSEL] ? baud_overflow : timer_ovf))
        else $error("transmit time base wrong");
    a_rx_base_mux: assert property (rx_time_base == (enh_ff[ENH_RXSEL] ? baud_overflow : timer_ovf))
        else $error("receive time base wrong");
    a_oe_level: assert property (clock_out_oe == enh_ff[ENH_CKOE])
        else $error("clock output enable wrong");
    a_pin_quiet: assert property (!clock_out_oe && !$past(clock_out_oe) |-> !clock_out_pin)
        else $error("clock output active while disabled");
    a_clk_toggle: assert property (clock_out_oe && $past(clock_out_oe) && $changed(clock_out_pin) |-> baud_overflow || $past(baud_overflow))
        else $error("clock output toggled without overflow");
    a_art_level: assert property (auto_repeat_tx == enh_ff[ENH_ART])
        else $error("auto repeat level wrong");
    a_ovf_pulse: assert property (baud_overflow |=> !baud_overflow)
        else $error("overflow longer than one cycle");
    a_mask_map: assert property (enh_wr && !ctrl_access_sel |=> addr_mask == $past(sfr_wdata))
        else $error("mask write missed");
    a_enh_map: assert property (enh_wr && ctrl_access_sel |=> $stable(addr_mask))
        else $error("mask changed by control write");
    a_done_pulse: assert property (tx_done_set || rx_done_set |=> !(tx_done_set || rx_done_set))
        else $error("done pulse too long");
    c_ovf_tx: cover property (baud_overflow && enh_ff[ENH_TXSEL]);
    c_tx_done: cover property (tx_done_set);
    c_rx_done: cover property (rx_done_set);
endmodule : ubg_top_props
bind ubg_top ubg_top_props u_props (.*);

// ==== test/ubg_lin_node.sv ====
// LIN node on the far side of the bus pin
`timescale 1ns/1ps
module ubg_lin_node (
    // clock
    input wire logic core_clk,
    // bus
    input wire logic lin_txd,
    output logic     lin_bus
);
    logic drive_ff = 1'b1;
    // wired-and bus with pull-up
    assign lin_bus = lin_txd & drive_ff;
    task automatic put(input logic v, input int n);
        drive_ff <= v;
        repeat (n) @(posedge core_clk);
    endtask : put
    // break, delimiter, then sync byte lsb first
    task automatic send_header(input int t);
        logic [9:0] fr;
        fr = 10'h2aa;
        put(1'b0, 13 * t);
        put(1'b1, t);
        for (int i = 0; i < 10; i++) put(fr[i], t);
    endtask : send_header
endmodule : ubg_lin_node

// ==== test/tb_ubg_top.sv ====
// self-checking bench for the baud generator and LIN extension
`timescale 1ns/1ps
module tb_ubg_top
    import ubg_pkg::*;
;
    logic       core_clk, rst_n, sfr_wr, sfr_rd, sfr_hit, ctrl_access_sel, timer_ovf;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sbuf_wdata, tx_data, addr_mask, aux_sel_page0, aux_sel_page3;
    logic [3:0] sfr_page;
    logic       sbuf_wr, sbuf_ready, tx_valid, tx_ready, baud_overflow, tx_time_base, rx_time_base;
    logic       tx_done_set, rx_done_set, auto_repeat_tx, lin_rxd, lin_txd, clock_out_pin, clock_out_oe;
    int         err_total = 0, check_count = 0, tx_dn = 0, rx_dn = 0, n;
    logic [1:0] mon;
    logic [7:0] q[$];
    assign mon = {lin_txd, baud_overflow};
    ubg_top uut (.data_order_bit(1'b0), .timer_mode(1'b0), .core_txd(1'b1), .*);
    ubg_lin_node node (.core_clk(core_clk), .lin_txd(lin_txd), .lin_bus(lin_rxd));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        timer_ovf <= 1'($urandom);
        if (tx_done_set === 1'b1) tx_dn <= tx_dn + 1;
        if (rx_done_set === 1'b1) rx_dn <= rx_dn + 1;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
        sfr_addr  <= a;
        sfr_page  <= p;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e, input logic h);
        sfr_addr <= a;
        sfr_page <= p;
        sfr_rd   <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        chk($sformatf("read %h", a), e, sfr_rdata);
        chk("hit", {7'h0, h}, {7'h0, sfr_hit});
        @(posedge core_clk);
    endtask : rc
    task automatic wait_on(input int k, input logic v, input int lim, output int c);
        c = 0;
        while (mon[k] !== v && c < lim) begin
            @(posedge core_clk);
            c++;
        end
        if (c >= lim) begin
            err_total++;
            $display("CHECK FAILED wait %0d exp %b seen timeout", k, v);
            end_of_test();
        end
    endtask : wait_on
    task automatic period(output int p);
        wait_on(0, 1'b1, 4000, p);
        @(posedge core_clk);
        wait_on(0, 1'b1, 4000, p);
        p++;
    endtask : period
    initial begin
        logic [7:0] v;
        int         b;
        void'($urandom(32'h535c));
        {rst_n, sfr_wr, sfr_rd, sfr_addr, sfr_page, sfr_wdata, ctrl_access_sel} = '0;
        {sbuf_wr, sbuf_wdata, tx_ready, timer_ovf} = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rc(ADDR_RELOAD, PAGE_0, 8'h00, 1'b1);
        rc(ADDR_LINCFG, PAGE_0, 8'h00, 1'b1);
        rc(ADDR_COUNTER, PAGE_0, 8'h00, 1'b1);
        rc(ADDR_AUX, PAGE_0, 8'h00, 1'b1);
        rc(ADDR_AUX, PAGE_3, 8'h00, 1'b1);
        rc(ADDR_ENH, PAGE_0, 8'h00, 1'b1);
        rc(8'h55, PAGE_0, 8'h00, 1'b0);
        v = $urandom;
        wr(ADDR_AUX, PAGE_0, v);
        wr(ADDR_AUX, PAGE_3, ~v);
        chk("aux0", v, aux_sel_page0);
        rc(ADDR_AUX, PAGE_3, ~v, 1'b1);
        v = 8'($urandom_range(0, 254));
        wr(ADDR_RELOAD, PAGE_0, v);
        rc(ADDR_COUNTER, PAGE_0, v, 1'b1);
        wr(ADDR_COUNTER, PAGE_0, v ^ 8'h5a);
        wr(ADDR_COUNTER, 4'h1, ~v);
        rc(ADDR_RELOAD, PAGE_0, v, 1'b1);
        rc(ADDR_COUNTER, PAGE_0, v ^ 8'h5a, 1'b1);
        v = $urandom & CFG_MASK;
        wr(ADDR_LINCFG, PAGE_0, v);
        rc(ADDR_LINCFG, PAGE_0, v, 1'b1);
        wr(ADDR_LINCFG, PAGE_0, 8'h00);
        ctrl_access_sel <= 1'b1;
        v = $urandom & 8'h7c;
        wr(ADDR_ENH, PAGE_0, v);
        rc(ADDR_ENH, 4'h5, v, 1'b1);
        ctrl_access_sel <= 1'b0;
        wr(ADDR_ENH, PAGE_0, ~v);
        chk("mask", ~v, addr_mask);
        ctrl_access_sel <= 1'b1;
        rc(ADDR_ENH, PAGE_0, v, 1'b1);
        wr(ADDR_RELOAD, PAGE_0, 8'hf0);
        for (b = 1; b >= 0; b--) begin
            wr(ADDR_ENH, PAGE_0, {1'b1, b[0], 6'h38});
            period(n);
            period(n);
            chk("period", b == 1 ? 8'h10 : 8'hc0, 8'(n));
        end
        wr(ADDR_ENH, PAGE_0, 8'h38);
        wr(ADDR_RELOAD, PAGE_0, 8'h33);
        repeat (100) @(posedge core_clk);
        rc(ADDR_COUNTER, PAGE_0, 8'h33, 1'b1);
        for (int i = 0; i < 3; i++) begin
            sbuf_wdata <= 8'ha0 + 8'(i);
            sbuf_wr    <= 1'b1;
            @(posedge core_clk);
        end
        sbuf_wr <= 1'b0;
        @(posedge core_clk);
        chk("ready", 8'h00, {7'h0, sbuf_ready});
        for (int i = 0; i < 60; i++) begin
            tx_ready <= 1'($urandom);
            @(posedge core_clk);
            if ((tx_valid & tx_ready) === 1'b1) q.push_back(tx_data);
        end
        chk("words", 8'h02, 8'(q.size()));
        chk("word1", 8'ha1, q[q.size() - 1]);
        chk("valid", 8'h00, {7'h0, tx_valid});
        tx_ready <= 1'b1;
        wr(ADDR_RELOAD, PAGE_0, 8'hfe);
        wr(ADDR_ENH, PAGE_0, 8'hc0);
        for (b = 0; b < 2; b++) begin
            wr(ADDR_LINCFG, PAGE_0, {2'b00, b[0], 5'h0c});
            sbuf_wdata <= 8'h3c;
            sbuf_wr    <= 1'b1;
            @(posedge core_clk);
            sbuf_wr <= 1'b0;
            wait_on(1, 1'b0, 200, n);
            wait_on(1, 1'b1, 900, n);
            chk("break", 8'h01, 8'(n >= (b ? 480 : 384) && n <= (b ? 544 : 448)));
            rc(ADDR_LINCFG, PAGE_0, {2'b10, b[0], 5'h08}, 1'b1);
            wr(ADDR_LINCFG, PAGE_0, 8'h00);
            rc(ADDR_LINCFG, PAGE_0, 8'h00, 1'b1);
        end
        for (b = 0; b < 2; b++) begin
            wr(ADDR_LINCFG, PAGE_0, {4'h0, b[0], 3'h0});
            node.put(1'b0, 96);
            node.put(1'b1, 8);
            rc(ADDR_LINCFG, PAGE_0, {1'b0, b[0], 2'b00, b[0], 3'h0}, 1'b1);
            wr(ADDR_LINCFG, PAGE_0, 8'h00);
        end
        rc(ADDR_LINCFG, PAGE_0, 8'h00, 1'b1);
        wr(ADDR_LINCFG, PAGE_0, 8'h14);
        node.send_header(64);
        repeat (64) @(posedge core_clk);
        rc(ADDR_RELOAD, PAGE_0, 8'hfc, 1'b1);
        rc(ADDR_LINCFG, PAGE_0, 8'h80, 1'b1);
        chk("txdone", 8'h02, 8'(tx_dn));
        chk("rxdone", 8'h01, 8'(rx_dn));
        end_of_test();
    end
endmodule : tb_ubg_top
